/* bfc_top.sv */
// The address map and register access over APB are this design's own decisions.
`default_nettype none
module bfc_top (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt request pins, active high
   input wire logic irq_pin,
   input wire logic nmi_pin,
   // status out
   output logic busy,
   output logic waiting
);
   import bfc_pkg::*;

   localparam int BFC_NPIN = 2;

   bfc_state_t state;
   logic [BFC_CNT_W-1:0] cnt;
   logic [7:0] opcode;
   logic [7:0] offset;
   logic [15:0] pc;
   logic [7:0] acc_a;
   logic [BFC_FLAG_W-1:0] flags;
   logic [BFC_FLAG_W-1:0] stacked;
   logic taken;
   logic illegal;
   logic mask_on_entry;
   logic [BFC_NPIN-1:0] pin_lvl;
   logic [BFC_NPIN-1:0] pins;
   logic irq;
   logic nmi;
   logic setup;
   logic wr;
   logic mapped;
   logic is_branch;
   logic take;
   logic [15:0] target;
   logic [BFC_CNT_W-1:0] next_len;
   logic legal;
   logic start;
   logic finish;
   logic wake;

   assign pins = {nmi_pin, irq_pin};

   // three stages; a change is accepted only when stages two and three agree
   // stages are local so no two processes share one variable
   for (genvar i = 0; i < BFC_NPIN; i++) begin : g_sync
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            lvl <= 1'b0;
         end else begin
            s1 <= pins[i];
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
               lvl <= s3;
            end
         end
      end
      assign pin_lvl[i] = lvl;
   end

   assign irq = pin_lvl[0];
   assign nmi = pin_lvl[1];

   // zero wait states: read data is captured in the setup cycle
   assign pready = 1'b1;
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite;
   assign mapped = (paddr[7:0] == BFC_REG_CMD) ||
      (paddr[7:0] == BFC_REG_PC) || (paddr[7:0] == BFC_REG_OFFSET) ||
      (paddr[7:0] == BFC_REG_ACC_A) || (paddr[7:0] == BFC_REG_FLAGS) ||
      (paddr[7:0] == BFC_REG_STACKED) || (paddr[7:0] == BFC_REG_STATUS);
   assign pslverr = psel & penable & ~(mapped && (paddr[31:8] == 24'h000000));

   bfc_branch_eval bfc_branch_eval_i (
      .opcode(opcode),
      .offset(offset),
      .pc(pc),
      .flags(flags),
      .is_branch(is_branch),
      .take(take),
      .target(target)
   );

   // length of the instruction written to the command register
   always_comb begin
      legal = 1'b1;
      if (pwdata[7:4] == BFC_OP_BRANCH_HI) begin
         next_len = BFC_CYC_BRANCH;
      end else begin
         unique case (pwdata[7:0])
            BFC_OP_ACC_A_TO_FLAGS, BFC_OP_FLAGS_TO_ACC_A,
            BFC_OP_CLEAR_CARRY, BFC_OP_SET_CARRY, BFC_OP_CLEAR_OVERFLOW,
            BFC_OP_SET_OVERFLOW, BFC_OP_CLEAR_MASK, BFC_OP_SET_MASK:
               next_len = BFC_CYC_FLAG_OP;
            BFC_OP_WAIT_FOR_INT: next_len = BFC_CYC_WAIT;
            BFC_OP_RETURN_FROM_INT: next_len = BFC_CYC_RETURN;
            default: begin
               next_len = BFC_CNT_ONE;
               legal = 1'b0;
            end
         endcase
      end
   end

   assign start = wr && (paddr[7:0] == BFC_REG_CMD) &&
      (state == BFC_ST_IDLE);
   assign finish = (state == BFC_ST_EXEC) && (cnt == BFC_CNT_ONE);
   // a mask already set on entry leaves only the nmi able to wake
   assign wake = (state == BFC_ST_WAIT) &&
      (nmi || (irq && !mask_on_entry));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= BFC_ST_IDLE;
         cnt <= '0;
         opcode <= '0;
         illegal <= 1'b0;
         mask_on_entry <= 1'b0;
      end else begin
         unique case (state)
            BFC_ST_IDLE: begin
               if (start) begin
                  illegal <= ~legal;
                  if (legal) begin
                     opcode <= pwdata[7:0];
                     cnt <= next_len;
                     state <= BFC_ST_EXEC;
                     mask_on_entry <= flags[BFC_F_I];
                  end
               end
            end
            BFC_ST_EXEC: begin
               cnt <= cnt - BFC_CNT_ONE;
               if (finish) begin
                  state <= (opcode == BFC_OP_WAIT_FOR_INT) ?
                     BFC_ST_WAIT : BFC_ST_IDLE;
               end
            end
            BFC_ST_WAIT: begin
               if (wake) begin
                  state <= BFC_ST_IDLE;
               end
            end
         endcase
      end
   end

   // program counter, accumulator and flags: software writes only while idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc <= '0;
         acc_a <= '0;
         flags <= BFC_FLAGS_RST;
         taken <= 1'b0;
      end else if (finish) begin
         taken <= is_branch & take;
         if (is_branch) begin
            // no branch touches the flags
            pc <= take ? target : pc + BFC_PC_STEP_BRANCH;
         end else begin
            if (opcode != BFC_OP_RETURN_FROM_INT &&
                opcode != BFC_OP_WAIT_FOR_INT) begin
               pc <= pc + BFC_PC_STEP_ONE;
            end
            unique case (opcode)
               BFC_OP_ACC_A_TO_FLAGS: flags <= acc_a[BFC_FLAG_W-1:0];
               BFC_OP_FLAGS_TO_ACC_A: acc_a <= {2'b00, flags};
               BFC_OP_RETURN_FROM_INT: flags <= stacked;
               BFC_OP_CLEAR_CARRY: flags[BFC_F_C] <= 1'b0;
               BFC_OP_SET_CARRY: flags[BFC_F_C] <= 1'b1;
               BFC_OP_CLEAR_OVERFLOW: flags[BFC_F_V] <= 1'b0;
               BFC_OP_SET_OVERFLOW: flags[BFC_F_V] <= 1'b1;
               BFC_OP_CLEAR_MASK: flags[BFC_F_I] <= 1'b0;
               BFC_OP_SET_MASK: flags[BFC_F_I] <= 1'b1;
               default: ;
            endcase
         end
      end else if (wake) begin
         // the taken interrupt masks further ones
         flags[BFC_F_I] <= 1'b1;
         pc <= pc + BFC_PC_STEP_ONE;
      end else if (wr && state == BFC_ST_IDLE) begin
         unique case (paddr[7:0])
            BFC_REG_PC: pc <= pwdata[15:0];
            BFC_REG_ACC_A: acc_a <= pwdata[7:0];
            BFC_REG_FLAGS: flags <= pwdata[BFC_FLAG_W-1:0];
            default: ;
         endcase
      end
   end

   // operand and stacked flags may be loaded at any time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         offset <= '0;
         stacked <= '0;
      end else if (wr && paddr[7:0] == BFC_REG_OFFSET) begin
         offset <= pwdata[7:0];
      end else if (wr && paddr[7:0] == BFC_REG_STACKED) begin
         stacked <= pwdata[BFC_FLAG_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (setup) begin
         prdata <= '0;
         if (paddr[31:8] == 24'h000000) begin
            unique case (paddr[7:0])
               BFC_REG_CMD: prdata[7:0] <= opcode;
               BFC_REG_PC: prdata[15:0] <= pc;
               BFC_REG_OFFSET: prdata[7:0] <= offset;
               BFC_REG_ACC_A: prdata[7:0] <= acc_a;
               BFC_REG_FLAGS: prdata[BFC_FLAG_W-1:0] <= flags;
               BFC_REG_STACKED: prdata[BFC_FLAG_W-1:0] <= stacked;
               BFC_REG_STATUS: begin
                  prdata[BFC_S_BUSY] <= (state != BFC_ST_IDLE);
                  prdata[BFC_S_WAIT] <= (state == BFC_ST_WAIT);
                  prdata[BFC_S_TAKEN] <= taken;
                  prdata[BFC_S_ILLEGAL] <= illegal;
                  prdata[BFC_S_IRQ] <= irq;
                  prdata[BFC_S_NMI] <= nmi;
               end
               default: ;
            endcase
         end
      end
   end

   assign busy = (state != BFC_ST_IDLE);
   assign waiting = (state == BFC_ST_WAIT);
endmodule : bfc_top
`default_nettype wire

/* bfc_pkg.sv */
`default_nettype none
package bfc_pkg;
   // register byte offsets on the apb bus
   localparam logic [7:0] BFC_REG_CMD = 8'h00;
   localparam logic [7:0] BFC_REG_PC = 8'h04;
   localparam logic [7:0] BFC_REG_OFFSET = 8'h08;
   localparam logic [7:0] BFC_REG_ACC_A = 8'h0C;
   localparam logic [7:0] BFC_REG_FLAGS = 8'h10;
   localparam logic [7:0] BFC_REG_STACKED = 8'h14;
   localparam logic [7:0] BFC_REG_STATUS = 8'h18;

   // condition_flags layout: h i n z v c
   localparam int BFC_FLAG_W = 6;
   localparam int BFC_F_C = 0;
   localparam int BFC_F_V = 1;
   localparam int BFC_F_Z = 2;
   localparam int BFC_F_N = 3;
   localparam int BFC_F_I = 4;
   localparam int BFC_F_H = 5;
   localparam logic [5:0] BFC_FLAGS_RST = 6'h10;

   // status register bits
   localparam int BFC_S_BUSY = 0;
   localparam int BFC_S_WAIT = 1;
   localparam int BFC_S_TAKEN = 2;
   localparam int BFC_S_ILLEGAL = 3;
   localparam int BFC_S_IRQ = 4;
   localparam int BFC_S_NMI = 5;

   // opcodes
   localparam logic [3:0] BFC_OP_BRANCH_HI = 4'h2;
   localparam logic [7:0] BFC_OP_BRANCH_ALWAYS = 8'h20;
   localparam logic [7:0] BFC_OP_BRANCH_NEVER = 8'h21;
   localparam logic [7:0] BFC_OP_UNSIGNED_HIGHER = 8'h22;
   localparam logic [7:0] BFC_OP_UNSIGNED_LOWER_SAME = 8'h23;
   localparam logic [7:0] BFC_OP_CARRY_CLEAR = 8'h24;
   localparam logic [7:0] BFC_OP_CARRY_SET = 8'h25;
   localparam logic [7:0] BFC_OP_ZERO_CLEAR = 8'h26;
   localparam logic [7:0] BFC_OP_ZERO_SET = 8'h27;
   localparam logic [7:0] BFC_OP_OVERFLOW_CLEAR = 8'h28;
   localparam logic [7:0] BFC_OP_OVERFLOW_SET = 8'h29;
   localparam logic [7:0] BFC_OP_POSITIVE = 8'h2A;
   localparam logic [7:0] BFC_OP_NEGATIVE = 8'h2B;
   localparam logic [7:0] BFC_OP_SIGNED_GE = 8'h2C;
   localparam logic [7:0] BFC_OP_SIGNED_LT = 8'h2D;
   localparam logic [7:0] BFC_OP_SIGNED_GT = 8'h2E;
   localparam logic [7:0] BFC_OP_SIGNED_LE = 8'h2F;
   localparam logic [7:0] BFC_OP_ACC_A_TO_FLAGS = 8'h06;
   localparam logic [7:0] BFC_OP_FLAGS_TO_ACC_A = 8'h07;
   localparam logic [7:0] BFC_OP_CLEAR_CARRY = 8'h00;
   localparam logic [7:0] BFC_OP_CLEAR_OVERFLOW = 8'h0A;
   localparam logic [7:0] BFC_OP_SET_OVERFLOW = 8'h0B;
   localparam logic [7:0] BFC_OP_SET_CARRY = 8'h0D;
   localparam logic [7:0] BFC_OP_CLEAR_MASK = 8'h0E;
   localparam logic [7:0] BFC_OP_SET_MASK = 8'h0F;
   localparam logic [7:0] BFC_OP_RETURN_FROM_INT = 8'h3B;
   localparam logic [7:0] BFC_OP_WAIT_FOR_INT = 8'h3E;

   // execution lengths in core cycles
   localparam int BFC_CNT_W = 4;
   localparam logic [3:0] BFC_CYC_BRANCH = 4'h3;
   localparam logic [3:0] BFC_CYC_FLAG_OP = 4'h2;
   localparam logic [3:0] BFC_CYC_WAIT = 4'h9;
   localparam logic [3:0] BFC_CYC_RETURN = 4'hA;
   localparam logic [3:0] BFC_CNT_ONE = 4'h1;

   localparam logic [15:0] BFC_PC_STEP_BRANCH = 16'h0002;
   localparam logic [15:0] BFC_PC_STEP_ONE = 16'h0001;

   typedef enum logic [2:0] {
      BFC_ST_IDLE = 3'b001,
      BFC_ST_EXEC = 3'b010,
      BFC_ST_WAIT = 3'b100
   } bfc_state_t;
endpackage : bfc_pkg
`default_nettype wire

/* bfc_branch_eval.sv */
`default_nettype none
module bfc_branch_eval (
   // instruction
   input wire logic [7:0] opcode,
   input wire logic [7:0] offset,
   input wire logic [15:0] pc,
   // flags
   input wire logic [bfc_pkg::BFC_FLAG_W-1:0] flags,
   // result
   output logic is_branch,
   output logic take,
   output logic [15:0] target
);
   import bfc_pkg::*;

   logic c;
   logic v;
   logic z;
   logic n;
   logic nxv;

   assign c = flags[BFC_F_C];
   assign v = flags[BFC_F_V];
   assign z = flags[BFC_F_Z];
   assign n = flags[BFC_F_N];
   assign nxv = n ^ v;
   assign is_branch = (opcode[7:4] == BFC_OP_BRANCH_HI);
   // sign-extended add carries or borrows into the high byte
   assign target = pc + BFC_PC_STEP_BRANCH + {{8{offset[7]}}, offset};

   always_comb begin
      unique case (opcode)
         BFC_OP_BRANCH_ALWAYS: take = 1'b1;
         BFC_OP_BRANCH_NEVER: take = 1'b0;
         BFC_OP_CARRY_CLEAR: take = ~c;
         BFC_OP_CARRY_SET: take = c;
         BFC_OP_ZERO_CLEAR: take = ~z;
         BFC_OP_ZERO_SET: take = z;
         BFC_OP_OVERFLOW_CLEAR: take = ~v;
         BFC_OP_OVERFLOW_SET: take = v;
         BFC_OP_POSITIVE: take = ~n;
         BFC_OP_NEGATIVE: take = n;
         BFC_OP_SIGNED_GE: take = ~nxv;
         BFC_OP_SIGNED_LT: take = nxv;
         BFC_OP_SIGNED_GT: take = ~(z | nxv);
         BFC_OP_SIGNED_LE: take = z | nxv;
         BFC_OP_UNSIGNED_HIGHER: take = ~(c | z);
         BFC_OP_UNSIGNED_LOWER_SAME: take = c | z;
         default: take = 1'b0;
      endcase
   end
endmodule : bfc_branch_eval
`default_nettype wire

/* bfc_top_monitor.sv */
`default_nettype none
module bfc_top_monitor (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins and status
   input wire logic irq_pin,
   input wire logic nmi_pin,
   input wire logic busy,
   input wire logic waiting
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic go;
   // a command is only started from idle
   assign go = psel && penable && pwrite && paddr == 32'h0 && !busy;
   a_branch_three: assert property (
      go && pwdata[7:4] == 4'h2 |=> busy [*3] ##1 !busy)
      else $error("branch length wrong");
   a_flag_two: assert property (
      go && pwdata[7:0] inside {8'h00, 8'h06, 8'h07, 8'h0A, 8'h0B,
      8'h0D, 8'h0E, 8'h0F} |=> busy [*2] ##1 !busy)
      else $error("flag op length wrong");
   a_wait_nine: assert property (
      go && pwdata[7:0] == 8'h3E |=> (busy && !waiting) [*8] ##1 busy
      ##1 waiting)
      else $error("wait ended early");
   a_return_ten: assert property (
      go && pwdata[7:0] == 8'h3B |=> busy [*5] ##1 busy [*5] ##1 !busy)
      else $error("return length wrong");
   a_wait_busy: assert property (waiting |-> busy)
      else $error("waiting without busy");
   a_quiet_hold: assert property (
      (!nmi_pin && !irq_pin) [*8] ##0 waiting |=> waiting)
      else $error("wait left without request");
   a_wake_pair: assert property ($fell(waiting) |-> $fell(busy))
      else $error("wake did not end busy");
   a_status_read: assert property (
      psel && !penable && !pwrite && paddr == 32'h18
      |=> prdata[1:0] == {$past(waiting), $past(busy)})
      else $error("status read wrong");
   c_branch: cover property (go && pwdata[7:4] == 4'h2);
   c_wake: cover property ($fell(waiting));
   c_return: cover property (go && pwdata[7:0] == 8'h3B);
endmodule : bfc_top_monitor
bind bfc_top bfc_top_monitor bfc_top_monitor_i (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .irq_pin, .nmi_pin, .busy, .waiting);
`default_nettype wire

/* bfc_top_tb.sv */
`default_nettype none
module bfc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import bfc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic irq_pin = 0, nmi_pin = 0, pready, pslverr, busy, waiting;
   logic [31:0] paddr = 0, pwdata = 0, prdata, q;
   logic [15:0] pc;
   logic [7:0] off, op;
   logic [5:0] fl;
   logic err;
   logic [7:0] sc_op [6] = '{BFC_OP_CLEAR_CARRY, BFC_OP_CLEAR_OVERFLOW,
      BFC_OP_SET_OVERFLOW, BFC_OP_SET_CARRY, BFC_OP_CLEAR_MASK,
      BFC_OP_SET_MASK};
   int n_fail = 0, comparisons = 0;
   bfc_top bfc_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .irq_pin, .nmi_pin, .busy,
      .waiting);
   always #50 pclk = ~pclk;
   task complete_run;
      if (n_fail == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task idle;
      for (int k = 0; k < 40; k++) begin
         @(negedge pclk);
         if (busy === 1'b0) break;
      end
      chk(busy, 0);
   endtask : idle
   task run(input logic [7:0] o);
      apb(1, BFC_REG_CMD, {24'h0, o});
      idle();
   endtask : run
   function logic take(input logic [3:0] o, input logic [5:0] f);
      logic c, v, z, n;
      {n, z, v, c} = f[3:0];
      case (o)
         4'h0: take = 1;
         4'h1: take = 0;
         4'h2: take = !(c | z);
         4'h3: take = c | z;
         4'h4: take = !c;
         4'h5: take = c;
         4'h6: take = !z;
         4'h7: take = z;
         4'h8: take = !v;
         4'h9: take = v;
         4'hA: take = !n;
         4'hB: take = n;
         4'hC: take = !(n ^ v);
         4'hD: take = n ^ v;
         4'hE: take = !(z | (n ^ v));
         default: take = z | (n ^ v);
      endcase
   endfunction : take
   function logic [5:0] after_op(input logic [7:0] o, input logic [5:0] f);
      after_op = f;
      case (o)
         BFC_OP_CLEAR_CARRY: after_op[BFC_F_C] = 1'b0;
         BFC_OP_SET_CARRY: after_op[BFC_F_C] = 1'b1;
         BFC_OP_CLEAR_OVERFLOW: after_op[BFC_F_V] = 1'b0;
         BFC_OP_SET_OVERFLOW: after_op[BFC_F_V] = 1'b1;
         BFC_OP_CLEAR_MASK: after_op[BFC_F_I] = 1'b0;
         default: after_op[BFC_F_I] = 1'b1;
      endcase
   endfunction : after_op
   initial begin
      #(100 * 20000);
      n_fail++;
      complete_run();
   end
   initial begin
      q = $urandom(22);
      repeat (20) @(posedge pclk);
      presetn <= 1;
      apb(0, BFC_REG_FLAGS, 0);
      chk(q, {26'h0, BFC_FLAGS_RST});
      chk(err, 0);
      apb(0, 8'h1C, 0);
      chk(q, 0);
      chk(err, 1);
      // every branch code, flags drawn at random, reach corners first
      for (int i = 0; i < 48; i++) begin
         op = 8'h20 | 8'(i % 16);
         fl = 6'($urandom);
         pc = (i == 2) ? 16'hFFFF : 16'($urandom);
         off = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : 8'($urandom);
         apb(1, BFC_REG_PC, {16'h0, pc});
         apb(1, BFC_REG_OFFSET, {24'h0, off});
         apb(1, BFC_REG_FLAGS, {26'h0, fl});
         run(op);
         apb(0, BFC_REG_PC, 0);
         chk(q, {16'h0, pc + 16'h2 + (take(op[3:0], fl) ?
            {{8{off[7]}}, off} : 16'h0)});
         apb(0, BFC_REG_FLAGS, 0);
         chk(q, {26'h0, fl});
         apb(0, BFC_REG_STATUS, 0);
         chk(q[BFC_S_TAKEN], take(op[3:0], fl));
      end
      // accumulator and flags transfers, both ways
      for (int i = 0; i < 8; i++) begin
         fl = 6'($urandom);
         apb(1, BFC_REG_ACC_A, {24'h0, 2'($urandom), fl});
         run(BFC_OP_ACC_A_TO_FLAGS);
         apb(0, BFC_REG_FLAGS, 0);
         chk(q, {26'h0, fl});
         apb(1, BFC_REG_FLAGS, {26'h0, ~fl});
         run(BFC_OP_FLAGS_TO_ACC_A);
         apb(0, BFC_REG_ACC_A, 0);
         chk(q, {26'h0, ~fl});
         apb(1, BFC_REG_STACKED, {26'h0, fl ^ 6'h15});
         run(BFC_OP_RETURN_FROM_INT);
         apb(0, BFC_REG_FLAGS, 0);
         chk(q, {26'h0, fl ^ 6'h15});
      end
      // masked wait: irq must not wake it, nmi must
      apb(1, BFC_REG_PC, 32'h1234);
      apb(1, BFC_REG_FLAGS, 32'h10);
      apb(1, BFC_REG_CMD, {24'h0, BFC_OP_WAIT_FOR_INT});
      repeat (12) @(negedge pclk);
      chk(waiting, 1);
      @(posedge pclk);
      irq_pin <= 1;
      repeat (12) @(negedge pclk);
      chk(waiting, 1);
      @(posedge pclk);
      nmi_pin <= 1;
      idle();
      @(posedge pclk);
      nmi_pin <= 0;
      irq_pin <= 0;
      apb(0, BFC_REG_PC, 0);
      chk(q, 32'h1235);
      // unmasked wait wakes on irq and sets the mask
      apb(1, BFC_REG_FLAGS, 32'h0);
      apb(1, BFC_REG_CMD, {24'h0, BFC_OP_WAIT_FOR_INT});
      repeat (12) @(negedge pclk);
      chk(waiting, 1);
      @(posedge pclk);
      irq_pin <= 1;
      idle();
      @(posedge pclk);
      irq_pin <= 0;
      apb(0, BFC_REG_FLAGS, 0);
      chk(q, 32'h10);
      // set and clear codes on random flags
      for (int i = 0; i < 12; i++) begin
         fl = 6'($urandom);
         apb(1, BFC_REG_FLAGS, {26'h0, fl});
         run(sc_op[i % 6]);
         apb(0, BFC_REG_FLAGS, 0);
         chk(q, {26'h0, after_op(sc_op[i % 6], fl)});
      end
      // reset in mid wait returns state and flags to reset values
      apb(1, BFC_REG_CMD, {24'h0, BFC_OP_WAIT_FOR_INT});
      repeat (12) @(negedge pclk);
      chk(waiting, 1);
      @(posedge pclk);
      presetn <= 0;
      repeat (3) @(posedge pclk);
      chk(busy, 0);
      chk(waiting, 0);
      presetn <= 1;
      apb(0, BFC_REG_FLAGS, 0);
      chk(q, {26'h0, BFC_FLAGS_RST});
      complete_run();
   end
endmodule : bfc_top_tb
`default_nettype wire
